// >>> hw/vlh_pkg.sv
// Purpose: Shared constants and types for the link host interface.
// Assumes: One 40 MHz core clock and a synchronous active-high reset.
// Notes: Register offsets are word indices on a two-bit address port.
package vlh_pkg;
    // Core clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 25;
    // Time the link clocks need to settle after a stop-mode wakeup.
    localparam int STAB_TIME_NS = 1000;
    // Settling time as whole cycles, rounded up.
    localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Register offsets.
    localparam logic [1:0] OFS_VECTOR = 2'h0;
    localparam logic [1:0] OFS_DATA = 2'h1;
    localparam logic [1:0] OFS_CTRL = 2'h2;
    localparam logic [1:0] OFS_STATUS = 2'h3;
    // Control register field positions.
    localparam int CTL_EOD_BIT = 0;
    localparam int CTL_WTS_BIT = 1;
    localparam int CTL_IRQEN_BIT = 2;
    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CODE = 4'h0;
    // Interrupt source codes, lowest priority first.
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_EOF = 4'h1;
    localparam logic [3:0] SRC_RX_IFR = 4'h2;
    localparam logic [3:0] SRC_RX_FULL = 4'h3;
    localparam logic [3:0] SRC_TX_EMPTY = 4'h4;
    localparam logic [3:0] SRC_ARB_LOSS = 4'h5;
    localparam logic [3:0] SRC_CRC_ERR = 4'h6;
    localparam logic [3:0] SRC_INVALID = 4'h7;
    localparam logic [3:0] SRC_WAKEUP = 4'h8;
    // Number of interrupt sources.
    localparam int NUM_SRC = 8;
    // Power modes, Gray coded along run, wait, stop, resume.
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_WAIT = 2'b01,
        PM_STOP = 2'b11,
        PM_RESUME = 2'b10
    } vlh_pm_t;
endpackage

// >>> hw/vlh_prio_enc.sv
// Purpose: Priority encoder that turns pending flags into a source code.
// Assumes: Flag bit i stands for source code i+1; higher code wins.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module vlh_prio_enc #(
    parameter int N = 8
) (
    input wire logic [N-1:0] pending,
    output logic [3:0] code
);
    import vlh_pkg::*;

    // The code must fit in four bits.
    if (N < 1 || N > 15) begin : g_bad_n
        $error("vlh_prio_enc: N must lie between 1 and 15");
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan upward so that the highest pending source is the last to win.
    always_comb
    begin
        code = SRC_NONE;
        for (int i = 0; i < N; i++)
        begin
            if (pending[i])
            begin
                code = 4'(i + 1);
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/vlh_link_host.sv
// Purpose: Host side of a VPW link controller: state vector, data buffers,
//          low-power modes.
// Assumes: The symbol engine reports events as one-cycle pulses.
// Notes: Registers sit on a two-bit word address with one-cycle read data.
//
// Contract
// - Report only highest-priority pending source code.
// - Vector value equals source code times four.
// - Vector read clears source, except data-service ones.
// - Receive flags clear on vector then data read.
// - Transmit-empty clears on vector then write, or end-of-data.
// - Vector shows remaining lower source immediately.
// - Data read returns last received byte.
// - Shadow moves to shifter; flag at first bit.
// - Completed byte copied to shadow, sets receive-full (or receive-IFR for a response byte).
// - Missing byte flags underrun and aborts transmitter.
// - Truncated frame reported as invalid symbol.
// - Wait mode entered; no bus driving there.
// - Wait mode receives, wakes, interrupts when enabled.
// - Stop mode via stop, or wait with select.
// - Bus activity in stop wakes, raises non-maskable request.
// - Waking byte valid only after wait with frame end.
// - Stop during reception wakes on edge, then settles.
// - End-of-data request sends end symbol after byte.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module vlh_link_host #(
    parameter int STAB_CNT = vlh_pkg::STAB_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ev_eof,
    input wire logic ev_arb_loss,
    input wire logic ev_crc_err,
    input wire logic ev_invalid_sym,
    input wire logic ev_frame_trunc,
    input wire logic rx_byte_done,
    input wire logic rx_is_ifr,
    input wire logic [7:0] rx_byte,
    input wire logic rx_busy,
    input wire logic tx_active,
    input wire logic tx_load_req,
    input wire logic tx_first_bit,
    input wire logic eod_done,
    output logic tx_load,
    output logic [7:0] tx_byte,
    output logic tx_underrun,
    output logic tx_abort,
    output logic eod_pending,
    output logic tx_drive_en,
    input wire logic cpu_wait,
    input wire logic cpu_stop,
    input wire logic bus_active,
    output logic link_clk_stop,
    output logic rx_wake_valid,
    output logic cpu_irq,
    output logic cpu_nmi,
    output logic [1:0] power_mode
);
    import vlh_pkg::*;

    // The settling counter is 16 bits wide and must count at least once.
    if (STAB_CNT < 1 || STAB_CNT > 65535) begin : g_bad_stab
        $error("vlh_link_host: STAB_CNT out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Access strobes per register.
    wire logic vec_read = reg_rd && (reg_addr == OFS_VECTOR);
    wire logic data_read = reg_rd && (reg_addr == OFS_DATA);
    wire logic data_write = reg_wr && (reg_addr == OFS_DATA);
    wire logic ctrl_write = reg_wr && (reg_addr == OFS_CTRL);

    // Pending source flags; bit i is source code i+1.
    logic [NUM_SRC-1:0] flags;
    // Highest pending source.
    logic [3:0] code;
    // Code captured at the last vector read that needs data service.
    logic [3:0] arm_code;
    // Receive and transmit shadow registers; only the transmit one has a valid mark.
    logic [7:0] rx_shadow;
    logic [7:0] tx_shadow;
    logic tx_shadow_valid;
    // Control bits.
    logic wait_to_stop_select;
    logic irq_enable_bit;
    // Power mode and helpers.
    vlh_pm_t pm;
    vlh_pm_t next_pm;
    logic bus_prev;
    logic eof_seen;
    logic [15:0] stab_count;

    ////////////////////////////////////////////////////////////////////////
    // Source encoding.

    vlh_prio_enc #(
        .N(NUM_SRC)
    ) u_enc (
        .pending(flags),
        .code(code)
    );

    // Passive-to-active bus transition.
    wire logic bus_rise = bus_active && !bus_prev;
    // Wakeup from stop mode on bus activity.
    wire logic wake_set = (pm == PM_STOP) && bus_rise;
    // The software end-of-data request.
    wire logic eod_set = ctrl_write && reg_wdata[CTL_EOD_BIT];
    // A vector read armed for data service.
    wire logic arm_rx = (arm_code == SRC_RX_FULL) || (arm_code == SRC_RX_IFR);
    wire logic arm_tx = (arm_code == SRC_TX_EMPTY);
    // Sources that stay until the data register is serviced.
    wire logic code_service = (code == SRC_RX_FULL) || (code == SRC_RX_IFR) ||
                              (code == SRC_TX_EMPTY);
    // Underrun: shifter wants a byte, none is there, and no end is asked.
    wire logic underrun_now = tx_load_req && !tx_shadow_valid && tx_active &&
                              !eod_pending;

    // Events that set each flag.
    wire logic [NUM_SRC-1:0] set_vec = {
        wake_set,
        ev_invalid_sym || ev_frame_trunc,
        ev_crc_err,
        ev_arb_loss,
        tx_first_bit,
        rx_byte_done && !rx_is_ifr,
        rx_byte_done && rx_is_ifr,
        ev_eof
    };

    ////////////////////////////////////////////////////////////////////////
    // Flag registers; a set in the clearing cycle wins.

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
        // This flag's source code.
        localparam logic [3:0] MY_CODE = 4'(i + 1);
        // Plain sources clear on a vector read that reports them.
        wire logic clr_read = vec_read && (code == MY_CODE) && !code_service;
        // Receive sources need the armed vector read and a data read.
        wire logic clr_rx = data_read && arm_rx && (arm_code == MY_CODE);
        // Transmit-empty clears on an armed write or an end request.
        wire logic clr_tx = (MY_CODE == SRC_TX_EMPTY) &&
                            ((data_write && arm_tx) || eod_set);
        wire logic next_flag = set_vec[i] || (flags[i] && !(clr_read || clr_rx || clr_tx));

        // One flip-flop per source.
        always_ff @(posedge core_clk)
        begin
            if (reset)
            begin
                flags[i] <= 1'b0;
            end
            else
            begin
                flags[i] <= next_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Service arming: remembers which buffer the host is about to touch.

    wire logic [3:0] next_arm = vec_read ? (code_service ? code : SRC_NONE) :
                                (data_read || data_write) ? SRC_NONE : arm_code;

    // Arming register.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            arm_code <= RST_CODE;
        end
        else
        begin
            arm_code <= next_arm;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the read strobe.

    wire logic [7:0] vec_value = {2'h0, code, 2'h0};
    wire logic [7:0] ctrl_value = {5'h00, irq_enable_bit, wait_to_stop_select, eod_pending};
    wire logic [7:0] status_value = {3'h0, pm, rx_wake_valid, tx_shadow_valid, tx_abort};
    wire logic [7:0] read_mux = (reg_addr == OFS_VECTOR) ? vec_value :
                                (reg_addr == OFS_DATA) ? rx_shadow :
                                (reg_addr == OFS_CTRL) ? ctrl_value : status_value;

    // Read data register; it drops to zero when no read was made.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reg_rdata <= RST_BYTE;
        end
        else
        begin
            reg_rdata <= reg_rd ? read_mux : RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register; the end request clears when the engine is done.

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wait_to_stop_select <= 1'b0;
            irq_enable_bit <= 1'b0;
            eod_pending <= 1'b0;
        end
        else
        begin
            if (ctrl_write)
            begin
                wait_to_stop_select <= reg_wdata[CTL_WTS_BIT];
                irq_enable_bit <= reg_wdata[CTL_IRQEN_BIT];
            end
            // The engine sends the end symbol after the held byte.
            eod_pending <= eod_set || (eod_pending && !eod_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive shadow: each completed byte overwrites the last one.

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rx_shadow <= RST_BYTE;
        end
        else if (rx_byte_done)
        begin
            rx_shadow <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit shadow and hand-over to the shifter.

    // Shadow fills on a host write and empties when the shifter takes it.
    wire logic take_shadow = tx_load_req && tx_shadow_valid;
    wire logic next_tx_valid = data_write || (tx_shadow_valid && !take_shadow);

    // A write that races the take refills the shadow, so no byte is lost.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tx_shadow <= RST_BYTE;
            tx_shadow_valid <= 1'b0;
            tx_byte <= RST_BYTE;
            tx_load <= 1'b0;
        end
        else
        begin
            if (data_write)
            begin
                tx_shadow <= reg_wdata;
            end
            if (take_shadow)
            begin
                tx_byte <= tx_shadow;
            end
            tx_shadow_valid <= next_tx_valid;
            tx_load <= take_shadow;
        end
    end

    // The abort holds until the engine ends the transmission.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tx_underrun <= 1'b0;
            tx_abort <= 1'b0;
        end
        else
        begin
            tx_underrun <= underrun_now;
            tx_abort <= underrun_now || (tx_abort && tx_active);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power modes.

    always_comb
    begin
        next_pm = pm;
        case (pm)
            PM_RUN:
            begin
                if (cpu_stop || (cpu_wait && wait_to_stop_select))
                begin
                    next_pm = PM_STOP;
                end
                else if (cpu_wait)
                begin
                    next_pm = PM_WAIT;
                end
            end
            PM_WAIT:
            begin
                // A good frame end wakes the block; the flag asks for service.
                if (ev_eof)
                begin
                    next_pm = PM_RUN;
                end
            end
            PM_STOP:
            begin
                if (bus_rise)
                begin
                    next_pm = PM_RESUME;
                end
            end
            PM_RESUME:
            begin
                if (stab_count == 16'(STAB_CNT - 1))
                begin
                    next_pm = PM_RUN;
                end
            end
            default:
            begin
                next_pm = PM_RUN;
            end
        endcase
    end

    // Mode register, bus edge history, settling count and frame-end memory.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pm <= PM_RUN;
            bus_prev <= 1'b0;
            stab_count <= 16'h0000;
            eof_seen <= 1'b0;
        end
        else
        begin
            pm <= next_pm;
            bus_prev <= bus_active;
            stab_count <= (pm == PM_RESUME) ? stab_count + 16'h0001 : 16'h0000;
            eof_seen <= ev_eof || (eof_seen && !rx_byte_done);
        end
    end

    // The waking byte is trusted only after wait-to-stop at a frame end.
    wire logic stop_entry = (pm == PM_RUN) && (next_pm == PM_STOP);
    wire logic good_entry = cpu_wait && !cpu_stop && eof_seen && !rx_busy;

    // Valid mark held from one stop entry to the next; the non-maskable request pulses for one cycle.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rx_wake_valid <= 1'b0;
            cpu_nmi <= 1'b0;
        end
        else
        begin
            if (stop_entry)
            begin
                rx_wake_valid <= good_entry;
            end
            cpu_nmi <= wake_set;
        end
    end

    // Outputs; driving stops in wait and stop, since the clocks may halt.
    assign tx_drive_en = (pm == PM_RUN);
    assign link_clk_stop = (pm == PM_STOP);
    assign cpu_irq = irq_enable_bit && (code != SRC_NONE);
    assign power_mode = pm;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_wakeup_top: assert property (flags[NUM_SRC-1] |-> code == SRC_WAKEUP)
        else $error("wakeup not reported as top source");
    a_vector_scale: assert property (vec_read |=> reg_rdata == {2'h0, $past(code), 2'h0})
        else $error("vector read is not code times four");
    a_eof_clear: assert property (vec_read && code == SRC_EOF && !ev_eof |=> !flags[0])
        else $error("frame end source not cleared by read");
    a_rx_hold: assert property ($fell(flags[2]) |-> $past(data_read && arm_rx))
        else $error("receive full cleared without service");
    a_tx_clear: assert property ($fell(flags[3]) |-> $past((data_write && arm_tx) || eod_set))
        else $error("transmit empty cleared without service");
    a_remain_show: assert property (flags[1] && flags[7:2] == 6'h00 |-> vec_value == 8'h08)
        else $error("remaining source not shown");
    a_tx_handoff: assert property (take_shadow |=> tx_load && tx_byte == $past(tx_shadow))
        else $error("shadow byte not handed to shifter");
    a_rx_copy: assert property (rx_byte_done |=> rx_shadow == $past(rx_byte) && |flags[2:1])
        else $error("received byte not copied");
    a_underrun_abort: assert property (underrun_now |=> tx_underrun && tx_abort)
        else $error("underrun not flagged");
    a_wait_quiet: assert property (pm == PM_WAIT |-> !tx_drive_en)
        else $error("bus driven in wait mode");
    a_stop_wake: assert property (wake_set |=> cpu_nmi && pm == PM_RESUME && flags[7])
        else $error("stop wakeup missing");
    a_stop_enter: assert property (pm == PM_RUN && cpu_stop |=> pm == PM_STOP ##1 !tx_drive_en)
        else $error("stop not entered");

    c_rx_service: cover property (vec_read && code == SRC_RX_FULL ##[1:4] data_read);
    c_underrun: cover property (tx_underrun);
    c_stop_wake: cover property (pm == PM_STOP ##[1:20] pm == PM_RESUME);
    c_wait_wake: cover property (pm == PM_WAIT ##[1:20] pm == PM_RUN);
endmodule
`default_nettype wire

// >>> test/vlh_engine_model.sv
// Purpose: Behavioural stand-in for the symbol engine and the bus side of the link.
// Assumes: The bench calls its tasks; every change lands just after a rising edge.
// Notes: Pulses last one cycle; receive data is scrambled outside its strobe.
`timescale 1ns/1ps
`default_nettype none
module vlh_engine_model (
    input wire logic core_clk,
    output logic ev_eof,
    output logic ev_arb_loss,
    output logic ev_crc_err,
    output logic ev_invalid_sym,
    output logic ev_frame_trunc,
    output logic rx_byte_done,
    output logic rx_is_ifr,
    output logic [7:0] rx_byte,
    output logic rx_busy,
    output logic tx_active,
    output logic tx_load_req,
    output logic tx_first_bit,
    output logic eod_done,
    output logic bus_active
);
    // One-cycle event lines, indexed by the bench: 0 eof, 1 arb, 2 crc,
    // 3 invalid, 4 truncated, 5 load request, 6 first bit, 7 end sent.
    logic [7:0] pl;
    // Load request and first bit come as separate calls, so the bench keeps their order.
    assign {eod_done, tx_first_bit, tx_load_req, ev_frame_trunc} = pl[7:4];
    assign {ev_invalid_sym, ev_crc_err, ev_arb_loss, ev_eof} = pl[3:0];
    // Quiet levels at time zero.
    initial
    begin
        rx_byte_done = 1'b0;
        rx_is_ifr = 1'b0;
        rx_byte = 8'h00;
        {pl, rx_busy, tx_active, bus_active} = 11'h000;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Raise one event line for exactly one cycle.
    task automatic pulse(input int b);
        @(posedge core_clk);
        pl[b] <= 1'b1;
        @(posedge core_clk);
        pl[b] <= 1'b0;
    endtask
    // Hand over one completed byte; afterwards the data lines no longer hold it.
    task automatic rx(input logic [7:0] d, input logic ifr);
        @(posedge core_clk);
        rx_byte <= d;
        rx_is_ifr <= ifr;
        rx_byte_done <= 1'b1;
        @(posedge core_clk);
        rx_byte_done <= 1'b0;
        rx_byte <= ~d;
        rx_is_ifr <= ~ifr;
    endtask
    // Set the reception, transmission and bus activity levels together.
    task automatic set_lvl(input logic [2:0] v);
        @(posedge core_clk);
        {rx_busy, tx_active, bus_active} <= v;
    endtask
endmodule
`default_nettype wire

// >>> test/vpw_link_host_interface_test.sv
// Purpose: Self-checking bench for the link host interface.
// Assumes: The engine model drives the far side; settle count cut to 3.
// Notes: Register strobes last one cycle and read data is checked the cycle after.
`timescale 1ns/1ps
`default_nettype none
module vpw_link_host_interface_test;
    import vlh_pkg::*;
    localparam int STAB = 3; // A short settle count keeps the run brief.
    logic core_clk, reset, reg_wr, reg_rd;
    logic cpu_wait, cpu_stop;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata, tx_byte;
    logic [1:0] power_mode;
    logic tx_load, tx_underrun, tx_abort, eod_pending, tx_drive_en;
    logic link_clk_stop, rx_wake_valid, cpu_irq, cpu_nmi;
    wire logic ev_eof, ev_arb_loss, ev_crc_err, ev_invalid_sym, ev_frame_trunc;
    wire logic rx_byte_done, rx_is_ifr, rx_busy, tx_active, tx_load_req;
    wire logic tx_first_bit, eod_done, bus_active;
    wire logic [7:0] rx_byte;
    int n_fail = 0, comparisons = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    vlh_link_host #(.STAB_CNT(STAB)) i_dut (.core_clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ev_eof, .ev_arb_loss, .ev_crc_err, .ev_invalid_sym,
        .ev_frame_trunc, .rx_byte_done, .rx_is_ifr, .rx_byte, .rx_busy, .tx_active,
        .tx_load_req, .tx_first_bit, .eod_done, .tx_load, .tx_byte, .tx_underrun, .tx_abort,
        .eod_pending, .tx_drive_en, .cpu_wait, .cpu_stop, .bus_active, .link_clk_stop,
        .rx_wake_valid, .cpu_irq, .cpu_nmi, .power_mode);
    vlh_engine_model i_eng (.core_clk, .ev_eof, .ev_arb_loss, .ev_crc_err, .ev_invalid_sym,
        .ev_frame_trunc, .rx_byte_done, .rx_is_ifr, .rx_byte, .rx_busy, .tx_active,
        .tx_load_req, .tx_first_bit, .eod_done, .bus_active);
    ////////////////////////////////////////////////////////////////////////////
    // Free-running 40 MHz core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard: the sequence needs under a thousand cycles.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Expected vector: the source code scaled for a four-byte table.
    function automatic logic [7:0] vec(input logic [3:0] code);
        return {2'b00, code, 2'b00};
    endfunction
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic check_mode(input logic [1:0] exp);
        comparisons++;
        if (power_mode !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: mode %b, expected %b", $time, power_mode, exp);
        end
    endtask
    // One-cycle register write.
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle register read; the data stand only in the following cycle.
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check8(reg_rdata, exp);
    endtask
    // A wait or stop instruction from the processor, then let the mode settle.
    task automatic cpu_ev(input logic stop);
        @(posedge core_clk);
        cpu_stop <= stop;
        cpu_wait <= ~stop;
        @(posedge core_clk);
        {cpu_stop, cpu_wait} <= 2'b00;
        @(posedge core_clk);
        #1;
    endtask
    // Bus activity wakes a stopped link; then it settles for STAB cycles.
    task automatic wake(input logic [2:0] lvl);
        int n;
        n = 0;
        i_eng.set_lvl(lvl);
        while (cpu_nmi !== 1'b1 && n < 8)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        check1(cpu_nmi, 1'b1);
        check_mode(PM_RESUME);
        @(posedge core_clk);
        #1 check_mode(PM_RESUME);
        repeat (STAB - 2) @(posedge core_clk);
        #1 check_mode(PM_RESUME);
        @(posedge core_clk);
        #1 check_mode(PM_RUN);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, vector priority, receive, transmit, power modes.
    initial
    begin
        {reset, reg_wr, reg_rd, cpu_wait, cpu_stop, reg_addr, reg_wdata} = 15'h4000;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        rd_chk(OFS_STATUS, 8'h00);
        wr_reg(OFS_VECTOR, 8'hff);
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        // Three sources at once; each vector read peels off the top one, but receive-full stays until the data read.
        i_eng.rx(8'h96, 1'b0);
        i_eng.pulse(1);
        i_eng.pulse(3);
        rd_chk(OFS_VECTOR, vec(SRC_INVALID));
        rd_chk(OFS_VECTOR, vec(SRC_ARB_LOSS));
        rd_chk(OFS_VECTOR, vec(SRC_RX_FULL));
        rd_chk(OFS_VECTOR, vec(SRC_RX_FULL));
        rd_chk(OFS_DATA, 8'h96);
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        // Two response bytes unread: the second overwrites the first.
        i_eng.rx(8'h11, 1'b1);
        i_eng.rx(8'h22, 1'b1);
        i_eng.pulse(2);
        rd_chk(OFS_VECTOR, vec(SRC_CRC_ERR));
        rd_chk(OFS_VECTOR, vec(SRC_RX_IFR));
        rd_chk(OFS_DATA, 8'h22);
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        // Transmit two bytes, then end the frame with the end request.
        i_eng.set_lvl(3'b010);
        wr_reg(OFS_DATA, 8'ha5);
        i_eng.pulse(5);
        #1 check1(tx_load, 1'b1);
        check8(tx_byte, 8'ha5);
        i_eng.pulse(6);
        rd_chk(OFS_VECTOR, vec(SRC_TX_EMPTY));
        wr_reg(OFS_DATA, 8'h3c);
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        i_eng.pulse(5);
        #1 check8(tx_byte, 8'h3c);
        i_eng.pulse(6);
        wr_reg(OFS_CTRL, 8'h01);
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        check1(eod_pending, 1'b1);
        i_eng.pulse(7);
        #1 check1(eod_pending, 1'b0);
        // No byte supplied on the next load request: underrun and abort.
        i_eng.pulse(5);
        #1 check1(tx_underrun, 1'b1);
        check1(tx_load, 1'b0);
        @(posedge core_clk);
        #1 check1(tx_abort, 1'b1);
        i_eng.set_lvl(3'b000);
        repeat (2) @(posedge core_clk);
        #1 check1(tx_abort, 0);
        i_eng.pulse(4);
        rd_chk(OFS_VECTOR, vec(SRC_INVALID));
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        // Wait mode: no driving, a received frame wakes and interrupts.
        wr_reg(OFS_CTRL, 8'h04);
        cpu_ev(1'b0);
        check_mode(PM_WAIT);
        check1(tx_drive_en, 1'b0);
        i_eng.rx(8'h5a, 1'b0);
        i_eng.pulse(0);
        @(posedge core_clk);
        #1 check_mode(PM_RUN);
        check1(cpu_irq, 1'b1);
        rd_chk(OFS_VECTOR, vec(SRC_RX_FULL));
        rd_chk(OFS_DATA, 8'h5a);
        rd_chk(OFS_VECTOR, vec(SRC_EOF));
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        check1(cpu_irq, 1'b0);
        // Wait with stop select after a frame end: the waking byte is good.
        wr_reg(OFS_CTRL, 8'h06);
        cpu_ev(1'b0);
        check_mode(PM_STOP);
        check1(link_clk_stop, 1'b1);
        check1(rx_wake_valid, 1'b1);
        wake(3'b001);
        rd_chk(OFS_VECTOR, vec(SRC_WAKEUP));
        rd_chk(OFS_VECTOR, vec(SRC_NONE));
        // Stop instruction in mid-reception: the waking message is not trusted.
        i_eng.set_lvl(3'b000);
        i_eng.rx(8'h77, 1'b0);
        i_eng.set_lvl(3'b100);
        cpu_ev(1'b1);
        check_mode(PM_STOP);
        check1(rx_wake_valid, 1'b0);
        wake(3'b101);
        rd_chk(OFS_VECTOR, vec(SRC_WAKEUP));
        rd_chk(OFS_VECTOR, vec(SRC_RX_FULL));
        i_eng.set_lvl(3'b000);
        wrap_up();
    end
endmodule
`default_nettype wire
